/* verilog/passthru_pkg.sv */
package passthru_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int WORD_W = ADDR_W + DATA_W;
  localparam int PINS = 4;
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 8;
  localparam int FIFO_DEPTH = 4;

  localparam logic [ADDR_W-1:0] CTRL_ADDR = 7'h20;
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_MASK = 8'hF0;
  localparam int READ_FLAG_BIT = 7;

  localparam int PIN4_SELECT_BIT = 7;
  localparam int PIN3_CLOCK_BIT = 6;
  localparam int PIN2_DATAIN_BIT = 5;
  localparam int PIN1_RETURN_BIT = 4;

  localparam logic [6:0] SYNC_INIT = 7'h4F;

  typedef enum logic [2:0] {
    IDLE_ST  = 3'b001,
    SHIFT_ST = 3'b010,
    ROUTE_ST = 3'b100
  } link_state_type;

endpackage

/* verilog/stream_if.sv */
`timescale 1ns/10ps
interface stream_if #(parameter int WIDTH = 15);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

/* verilog/sync2.sv */
`timescale 1ns/10ps
module sync2 #(
  parameter int               WIDTH = 7,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage;

  // The first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage <= INIT;
      q     <= INIT;
    end else begin
      stage <= d;
      q     <= stage;
    end
  end

endmodule

/* verilog/stream_fifo.sv */
`timescale 1ns/10ps
module stream_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  stream_if.sink   fill,
  stream_if.source drain
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign fill.ready  = (count != (PW+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rd_ptr];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* verilog/passthrough_mux.sv */
// Functional notes
// - Routing starts at chip-select rise ending a control write with any enable set.
// - Routing lasts while chip select stays high, across many downstream transfers.
// - Routing ends at once when chip select falls for a device transfer.
// - Control holds four enables in bits 7..4, low bits unused, reset zero.
// - Pin 4 enable drives pin 4 low while routing, high otherwise.
// - Pin 3 enable drives pin 3 with serial clock while routing.
// - Pin 2 enable drives pin 2 with serial data input while routing.
// - Pin 1 enable returns pin 1 level onto serial data output while routing.
// - Pin level and edge flags keep tracking routed pins.
// - Outside routing each pin follows its own mode and level logic, except pin 4 while its enable is set.
// - Routed pins drive at the rail chosen by their supply select.
// - Supply select zero picks digital supply, one the charge pump, all modes.
`timescale 1ns/10ps
module passthrough_mux (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              cs_n,
  input  wire logic                              sclk,
  input  wire logic                              din,
  output logic                                   dout,
  output logic                                   dout_oe,
  input  wire logic [passthru_pkg::PINS-1:0]     user_pin_in,
  output logic      [passthru_pkg::PINS-1:0]     user_pin_out,
  output logic      [passthru_pkg::PINS-1:0]     user_pin_oe,
  input  wire logic [passthru_pkg::PINS-1:0]     pin_normal_out,
  input  wire logic [passthru_pkg::PINS-1:0]     pin_normal_oe,
  input  wire logic [passthru_pkg::PINS-1:0]     pin_supply_select,
  output logic      [passthru_pkg::PINS-1:0]     pin_rail_cp,
  output logic      [passthru_pkg::PINS-1:0]     pin_level,
  output logic      [passthru_pkg::PINS-1:0]     pin_rise_flag,
  output logic      [passthru_pkg::PINS-1:0]     pin_fall_flag,
  output logic                                   route_active,
  output logic      [passthru_pkg::ADDR_W-1:0]   reg_read_addr,
  input  wire logic [passthru_pkg::DATA_W-1:0]   reg_read_data,
  output logic                                   reg_write_valid,
  output logic      [passthru_pkg::ADDR_W-1:0]   reg_write_addr,
  output logic      [passthru_pkg::DATA_W-1:0]   reg_write_data,
  input  wire logic                              reg_write_ready,
  output logic                                   reg_write_overrun
);
  import passthru_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection.

  logic [6:0]          raw_in;
  logic [6:0]          synced;
  logic                cs_n_s;
  logic                sclk_s;
  logic                din_s;
  logic [PINS-1:0]     pin_s;
  logic                cs_n_d;
  logic                sclk_d;
  logic [PINS-1:0]     pin_d;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_rise;

  assign raw_in = {cs_n, sclk, din, user_pin_in};

  sync2 #(.WIDTH(7), .INIT(SYNC_INIT)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (raw_in),
    .q       (synced)
  );

  assign cs_n_s    = synced[6];
  assign sclk_s    = synced[5];
  assign din_s     = synced[4];
  assign pin_s     = synced[3:0];
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign cs_rise   = cs_n_s & ~cs_n_d;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_n_d <= SYNC_INIT[6];
      sclk_d <= SYNC_INIT[5];
      pin_d  <= SYNC_INIT[3:0];
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
      pin_d  <= pin_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame: command byte then data byte, sampled on rising clock.

  logic [4:0]            bit_cnt;
  logic [FRAME_BITS-1:0] shift_in;
  logic [DATA_W-1:0]     shift_out;
  logic                  read_frame;
  logic                  write_done;
  logic                  ctrl_write;
  logic [DATA_W-1:0]     ctrl;

  assign write_done = cs_rise && (bit_cnt == 5'(FRAME_BITS)) && !shift_in[FRAME_BITS-1];
  assign ctrl_write = write_done && (shift_in[FRAME_BITS-2:DATA_W] == CTRL_ADDR);

  always_ff @(posedge clk) begin
    if (sys_rst || cs_n_s) begin
      bit_cnt  <= '0;
      shift_in <= '0;
    end else if (sclk_rise && bit_cnt != 5'(FRAME_BITS)) begin
      shift_in <= {shift_in[FRAME_BITS-2:0], din_s};
      bit_cnt  <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_read_addr <= '0;
      read_frame    <= 1'b0;
    end else if (bit_cnt == 5'(CMD_BITS) && !cs_n_s) begin
      reg_read_addr <= shift_in[ADDR_W-1:0];
      read_frame    <= shift_in[READ_FLAG_BIT];
    end
  end

  // Readback loads on the falling clock after the command byte.
  always_ff @(posedge clk) begin
    if (sys_rst || cs_n_s) begin
      shift_out <= '0;
    end else if (sclk_fall && bit_cnt == 5'(CMD_BITS)) begin
      if (!read_frame) begin
        shift_out <= '0;
      end else if (reg_read_addr == CTRL_ADDR) begin
        shift_out <= ctrl & CTRL_MASK;
      end else begin
        shift_out <= reg_read_data;
      end
    end else if (sclk_fall && bit_cnt > 5'(CMD_BITS)) begin
      shift_out <= {shift_out[DATA_W-2:0], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register and routing state.

  link_state_type state;
  link_state_type next_state;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_write) begin
      ctrl <= shift_in[DATA_W-1:0] & CTRL_MASK;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      IDLE_ST: begin
        if (!cs_n_s) begin
          next_state = SHIFT_ST;
        end
      end
      SHIFT_ST: begin
        if (cs_rise) begin
          if (ctrl_write && (shift_in[DATA_W-1:0] & CTRL_MASK) != '0) begin
            next_state = ROUTE_ST;
          end else begin
            next_state = IDLE_ST;
          end
        end
      end
      ROUTE_ST: begin
        if (!cs_n_s) begin
          next_state = SHIFT_ST;
        end else begin
          next_state = ROUTE_ST;
        end
      end
      default: next_state = IDLE_ST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IDLE_ST;
    end else begin
      state <= next_state;
    end
  end

  assign route_active = (state == ROUTE_ST);

  //////////////////////////////////////////////////////////////////////////////
  // Writes to other registers leave through the FIFO.

  stream_if #(.WIDTH(WORD_W)) fill_if ();
  stream_if #(.WIDTH(WORD_W)) drain_if ();

  logic              pend;
  logic [WORD_W-1:0] pend_word;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend              <= 1'b0;
      pend_word         <= '0;
      reg_write_overrun <= 1'b0;
    end else begin
      reg_write_overrun <= write_done && !ctrl_write && pend && !fill_if.ready;
      if (write_done && !ctrl_write) begin
        pend      <= 1'b1;
        pend_word <= shift_in[WORD_W-1:0];
      end else if (fill_if.ready) begin
        pend <= 1'b0;
      end
    end
  end

  assign fill_if.valid   = pend;
  assign fill_if.data    = pend_word;
  assign drain_if.ready  = reg_write_ready;
  assign reg_write_valid = drain_if.valid;
  assign reg_write_addr  = drain_if.data[WORD_W-1:DATA_W];
  assign reg_write_data  = drain_if.data[DATA_W-1:0];

  stream_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .fill    (fill_if.sink),
    .drain   (drain_if.source)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin and serial output muxing.

  logic [PINS-1:0] route_on;
  logic [PINS-1:0] route_src;
  logic            return_on;

  assign return_on = route_active & ctrl[PIN1_RETURN_BIT];
  assign route_on  = {ctrl[PIN4_SELECT_BIT],
                      ctrl[PIN3_CLOCK_BIT] & route_active,
                      ctrl[PIN2_DATAIN_BIT] & route_active,
                      return_on};
  assign route_src = {~route_active, sclk_s, din_s, 1'b0};

  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          user_pin_out[i] <= 1'b0;
          user_pin_oe[i]  <= 1'b0;
        end else if (route_on[i]) begin
          user_pin_out[i] <= route_src[i];
          user_pin_oe[i]  <= (i != 0);
        end else begin
          user_pin_out[i] <= pin_normal_out[i];
          user_pin_oe[i]  <= pin_normal_oe[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else if (return_on) begin
      dout    <= pin_s[0];
      dout_oe <= 1'b1;
    end else begin
      dout    <= shift_out[DATA_W-1];
      dout_oe <= ~cs_n_s;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_rail_cp   <= '0;
      pin_level     <= '0;
      pin_rise_flag <= '0;
      pin_fall_flag <= '0;
    end else begin
      pin_rail_cp   <= pin_supply_select;
      pin_level     <= pin_s;
      pin_rise_flag <= pin_s & ~pin_d;
      pin_fall_flag <= ~pin_s & pin_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence enable_write_end;
    ctrl_write && (shift_in[DATA_W-1:0] & CTRL_MASK) != '0 && state == SHIFT_ST;
  endsequence

  sequence device_frame_start;
    route_active && !cs_n_s;
  endsequence

  a_route_entry: assert property (enable_write_end |=> route_active)
    else $error("Routing did not start after enabling write.");
  a_route_hold: assert property (route_active && cs_n_s |=> route_active)
    else $error("Routing dropped while chip select high.");
  a_route_exit: assert property (device_frame_start |=> !route_active ##1 !route_active)
    else $error("Routing did not end on chip select low.");
  a_ctrl_low_zero: assert property (ctrl[3:0] == 4'h0)
    else $error("Control low bits not zero.");
  a_pin4_select: assert property (ctrl[PIN4_SELECT_BIT] |=>
    user_pin_oe[3] && user_pin_out[3] == !$past(route_active))
    else $error("Pin 4 not inverse of routing.");
  a_pin3_clock: assert property (route_active && ctrl[PIN3_CLOCK_BIT] |=>
    user_pin_oe[2] && user_pin_out[2] == $past(sclk_s))
    else $error("Pin 3 not serial clock.");
  a_pin2_data: assert property (route_active && ctrl[PIN2_DATAIN_BIT] |=>
    user_pin_oe[1] && user_pin_out[1] == $past(din_s))
    else $error("Pin 2 not serial data.");
  a_pin1_return: assert property (return_on |=> dout_oe && dout == $past(pin_s[0])
    && !user_pin_oe[0])
    else $error("Pin 1 not returned to serial output.");
  a_edge_track: assert property ($rose(pin_s[0]) |=> pin_rise_flag[0] ##1 !pin_rise_flag[0])
    else $error("Rise flag missed pin edge.");
  a_normal_pins: assert property (!route_active && !ctrl[PIN4_SELECT_BIT] |=>
    user_pin_out == $past(pin_normal_out) && user_pin_oe == $past(pin_normal_oe))
    else $error("Pins not on normal mode outside routing.");
  a_rail_select: assert property (1'b1 |=> pin_rail_cp == $past(pin_supply_select))
    else $error("Rail select not following supply select.");
  a_dout_readback: assert property (!return_on && !cs_n_s |=>
    dout == $past(shift_out[DATA_W-1]) && dout_oe)
    else $error("Serial output not carrying readback.");

endmodule

/* tb/far_side_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Downstream device, pin pull-ups and the register file behind the write port.
module far_side_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [3:0]  pin_out,
  input  wire logic [3:0]  pin_oe,
  input  wire logic [6:0]  rd_addr,
  output logic      [7:0]  rd_data,
  input  wire logic        wr_valid,
  input  wire logic [14:0] wr_word,
  output logic             wr_ready,
  output logic      [3:0]  pin_in
);
  logic [14:0] popped[$];
  logic        selected;
  ////////////////////////////////////////////////////////////////////////////////
  // The downstream device echoes its data line back only while selected.
  assign selected = pin_oe[3] && !pin_out[3];
  assign pin_in[3:1] = pin_out[3:1] | ~pin_oe[3:1];
  assign pin_in[0] = pin_oe[0] ? pin_out[0] : (selected ? pin_in[1] : 1'b1);
  assign rd_data = {1'b1, rd_addr} ^ 8'h3C;
  assign wr_ready = !stall;
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      popped.push_back(wr_word);
    end
  end
endmodule

/* tb/spi_passthrough_mux_bench.sv */
`timescale 1ns/10ps
module spi_passthrough_mux_bench;
  import passthru_pkg::*;
  logic       clk, sys_rst, cs_n, sclk, din, dout, dout_oe, route_active, stall;
  logic [3:0] user_pin_in, user_pin_out, user_pin_oe, pin_normal_out, pin_normal_oe;
  logic [3:0] pin_supply_select, pin_rail_cp, pin_level, pin_rise_flag, pin_fall_flag;
  logic [6:0] reg_read_addr, reg_write_addr;
  logic [7:0] reg_read_data, reg_write_data, rd;
  logic       reg_write_valid, reg_write_ready, reg_write_overrun, prev;
  int         miscompares, checks_done, rises, falls, overruns, rise_base, fall_base;
  ////////////////////////////////////////////////////////////////////////////////
  passthrough_mux uut (.clk, .sys_rst, .cs_n, .sclk, .din, .dout, .dout_oe,
    .user_pin_in, .user_pin_out, .user_pin_oe, .pin_normal_out, .pin_normal_oe,
    .pin_supply_select, .pin_rail_cp, .pin_level, .pin_rise_flag, .pin_fall_flag,
    .route_active, .reg_read_addr, .reg_read_data, .reg_write_valid, .reg_write_addr,
    .reg_write_data, .reg_write_ready, .reg_write_overrun);
  far_side_model partner (.clk(clk), .stall(stall), .pin_out(user_pin_out),
    .pin_oe(user_pin_oe), .rd_addr(reg_read_addr), .rd_data(reg_read_data),
    .wr_valid(reg_write_valid), .wr_word({reg_write_addr, reg_write_data}),
    .wr_ready(reg_write_ready), .pin_in(user_pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    rises <= rises + int'(pin_rise_flag[0]);
    falls <= falls + int'(pin_fall_flag[0]);
    overruns <= overruns + int'(reg_write_overrun);
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One sclk period of eight clocks; dout is taken late in the high half.
  task automatic frame(input logic [15:0] word, output logic [7:0] data);
    @(posedge clk);
    cs_n <= 1'b0;
    tick(3);
    for (int i = 15; i >= 0; i--) begin
      din <= word[i];
      sclk <= 1'b0;
      tick(4);
      sclk <= 1'b1;
      tick(3);
      #1;
      if (i < 8) data[i] = dout;
      tick(1);
    end
    sclk <= 1'b0;
    tick(4);
    cs_n <= 1'b1;
    tick(10);
  endtask
  task automatic wait_route(input logic exp);
    int n;
    n = 0;
    while (route_active !== exp && n < 12) begin
      tick(1);
      n++;
    end
    check("route_active", route_active, exp);
    if (n == 12) test_done();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    {sys_rst, cs_n, sclk, din, stall} = 5'b11000;
    {pin_normal_out, pin_normal_oe, pin_supply_select} = 12'hAF6;
    miscompares = 0;
    checks_done = 0;
    tick(5);
    sys_rst <= 1'b0;
    tick(4);
    check("rail", pin_rail_cp, 4'h6);
    check("normal pins", {user_pin_out, user_pin_oe}, 8'hAF);
    frame(16'hA000, rd);
    check("ctrl reset", rd, CTRL_RESET);
    frame(16'hA500, rd);
    check("readback", rd, 8'hA5 ^ 8'h3C);
    frame(16'h200F, rd);
    check("no enable", route_active, 1'b0);
    frame(16'h20FF, rd);
    wait_route(1'b1);
    frame(16'hA000, rd);
    check("ctrl bits", rd, 8'hF0);
    check("read exits", route_active, 1'b0);
    frame(16'h20FF, rd);
    wait_route(1'b1);
    pin_normal_oe <= 4'h0;
    pin_supply_select <= 4'h9;
    tick(4);
    check("pin4 low", {user_pin_out[3], user_pin_oe[3]}, 2'b01);
    check("rail routed", pin_rail_cp, 4'h9);
    check("pin1 released", user_pin_oe[0], 1'b0);
    check("dout driven", dout_oe, 1'b1);
    tick(4);
    rise_base = rises;
    fall_base = falls;
    for (int i = 7; i >= 0; i--) begin
      din <= i[0] ^ i[2];
      sclk <= 1'b0;
      tick(3);
      #1;
      check("pin3 low", user_pin_out[2], 1'b0);
      check("pin2 data", user_pin_out[1], i[0] ^ i[2]);
      if (i < 7) check("dout return", dout, prev);
      tick(1);
      sclk <= 1'b1;
      tick(3);
      #1;
      check("pin3 high", user_pin_out[2], 1'b1);
      check("pin1 level", pin_level[0], i[0] ^ i[2]);
      check("route hold", route_active, 1'b1);
      prev = i[0] ^ i[2];
      tick(1);
    end
    check("pin1 rises", rises - rise_base, 3);
    check("pin1 falls", falls - fall_base, 4);
    sclk <= 1'b0;
    cs_n <= 1'b0;
    tick(1);
    wait_route(1'b0);
    tick(1);
    check("pin4 high", {user_pin_out[3], user_pin_oe[3]}, 2'b11);
    cs_n <= 1'b1;
    tick(10);
    check("no reentry", route_active, 1'b0);
    stall <= 1'b1;
    for (int k = 1; k <= 6; k++) begin
      frame({1'b0, 7'(k), 8'(8'h10 + k)}, rd);
    end
    check("overrun", overruns, 1);
    stall <= 1'b0;
    tick(20);
    check("pops", partner.popped.size(), 5);
    check("drained", reg_write_valid, 1'b0);
    for (int k = 0; k < 5; k++) begin
      check("word", partner.popped[k], {1'b0, 7'(k + 1 + k / 4), 8'(8'h11 + k + k / 4)});
    end
    sys_rst <= 1'b1;
    tick(5);
    sys_rst <= 1'b0;
    tick(4);
    frame(16'hA000, rd);
    check("ctrl after reset", rd, CTRL_RESET);
    test_done();
  end
endmodule
